// *** inc/afc_pkg.sv ***
// shared constants of the axis fault code detector
package afc_pkg;
    localparam int NUM_AXES = 4;
    localparam logic [31:0] CODE_GROUP_OP = 32'h0000_3032;
    localparam logic [31:0] CODE_INTERP = 32'h0000_3033;
    localparam logic [31:0] CODE_PULSER = 32'h0000_3034;
    localparam logic [31:0] CODE_MOVE_AMT = 32'h0000_3035;
    localparam logic [31:0] CODE_SYNC = 32'h0000_3043;
    localparam logic [31:0] CODE_SYNC_SET = 32'h0000_3046;
    localparam logic [31:0] CODE_TORQUE = 32'h0000_3050;
    localparam logic [31:0] CODE_SPEED = 32'h0000_3051;
    localparam logic [31:0] CODE_HOME = 32'h0000_3060;
    localparam logic [31:0] CODE_MTCLR = 32'h0000_3061;
    localparam logic [31:0] CODE_LATCH = 32'h0000_3070;
    // monitored-value error setting bits
    localparam int MON_TRQ_EN = 0;
    localparam int MON_TRQ_WARN = 1;
    localparam int MON_SPD_EN = 2;
    localparam int MON_SPD_WARN = 3;
    // register byte offsets
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_MONSET = 8'h08;
    localparam logic [7:0] REG_MOVE_HI = 8'h0C;
    localparam logic [7:0] REG_MOVE_LO = 8'h10;
    localparam logic [7:0] REG_CODE0 = 8'h20;
    localparam logic [31:0] MOVE_HI_RST = 32'h7FFF_FFFF;
    localparam logic [31:0] MOVE_LO_RST = 32'h8000_0000;
    localparam logic [3:0] MON_RST = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hdl/afc_sync2.sv ***
// two flip-flop synchroniser for a bundle of levels
`timescale 1ns/1ps
`default_nettype none
module afc_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

// *** hdl/afc_axis.sv ***
// per-axis fault detection and error code holder
`timescale 1ns/1ps
`default_nettype none
module afc_axis (
    input wire logic clk,
    input wire logic rst,
    input wire logic grp_chg,
    input wire logic grp_bad,
    input wire logic busy,
    input wire logic stop_req,
    input wire logic pulser_en,
    input wire logic move_req,
    input wire logic signed [31:0] move_amt,
    input wire logic signed [31:0] move_hi,
    input wire logic signed [31:0] move_lo,
    input wire logic interp_peer_err,
    input wire logic sync_peer_err,
    input wire logic sync_set_req,
    input wire logic sync_slave_off,
    input wire logic [3:0] mon_set,
    input wire logic trq_over,
    input wire logic spd_over,
    input wire logic home_req,
    input wire logic home_bad,
    input wire logic mtclr_req,
    input wire logic servo_on,
    input wire logic incr_mode,
    input wire logic abs_single,
    input wire logic full_closed,
    input wire logic latch_trig,
    input wire logic pos_done,
    input wire logic clr,
    output logic err_r,
    output logic [31:0] code_r,
    output logic stop_r,
    output logic event_r
);
    logic latch_seen_r;
    logic [31:0] det_code;
    logic det;
    wire logic move_out = move_req && (move_amt > move_hi || move_amt < move_lo);
    wire logic mtclr_bad = mtclr_req && (servo_on || incr_mode || abs_single || full_closed);
    wire logic latch_twice = latch_trig && latch_seen_r && !pos_done;
    wire logic trq_err = trq_over && mon_set[afc_pkg::MON_TRQ_EN] && !mon_set[afc_pkg::MON_TRQ_WARN];
    wire logic spd_err = spd_over && mon_set[afc_pkg::MON_SPD_EN] && !mon_set[afc_pkg::MON_SPD_WARN];
    wire logic peer_stop = interp_peer_err || sync_peer_err;

    // fixed priority: 0x3034 first, then lowest code first
    always_comb begin
        det = 1'b1;
        det_code = '0;
        if (grp_chg && pulser_en) begin
            det_code = afc_pkg::CODE_PULSER;
        end else if ((grp_chg && (busy || stop_req)) || grp_bad) begin
            det_code = afc_pkg::CODE_GROUP_OP;
        end else if (interp_peer_err) begin
            det_code = afc_pkg::CODE_INTERP;
        end else if (move_out) begin
            det_code = afc_pkg::CODE_MOVE_AMT;
        end else if (sync_peer_err) begin
            det_code = afc_pkg::CODE_SYNC;
        end else if (sync_set_req && sync_slave_off) begin
            det_code = afc_pkg::CODE_SYNC_SET;
        end else if (trq_err) begin
            det_code = afc_pkg::CODE_TORQUE;
        end else if (spd_err) begin
            det_code = afc_pkg::CODE_SPEED;
        end else if (home_req && home_bad) begin
            det_code = afc_pkg::CODE_HOME;
        end else if (mtclr_bad) begin
            det_code = afc_pkg::CODE_MTCLR;
        end else if (latch_twice) begin
            det_code = afc_pkg::CODE_LATCH;
        end else begin
            det = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || pos_done) begin
            latch_seen_r <= 1'b0;
        end else if (latch_trig) begin
            latch_seen_r <= 1'b1;
        end
    end

    // first code held; new detection wins over clear
    always_ff @(posedge clk) begin
        if (rst) begin
            err_r <= 1'b0;
            code_r <= '0;
        end else if (det && (!err_r || clr)) begin
            err_r <= 1'b1;
            code_r <= det_code;
        end else if (clr) begin
            err_r <= 1'b0;
            code_r <= '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stop_r <= 1'b0;
            event_r <= 1'b0;
        end else begin
            stop_r <= peer_stop;
            event_r <= det;
        end
    end
endmodule
`default_nettype wire

// *** hdl/afc_top.sv ***
// axis fault code detector top with AXI4-Lite register slave
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - A group change while busy or stop pending, or bad group settings, reports 0x3032.
// - An error on a peer interpolation axis stops this axis and reports 0x3033.
// - A group change during pulser operation is refused with 0x3034.
// - An error on a peer synchronous axis stops this axis and reports 0x3043.
// - Synchronous setup with pulse master while a slave is servo off reports 0x3046.
// - Torque beyond judgment with setting bit0 set and bit1 clear reports 0x3050.
// - Speed beyond judgment with setting bit2 set and bit3 clear reports 0x3051.
// - Home return that the amplifier cannot do is refused with 0x3060.
// - Multi-turn clear with servo on, incremental, single-turn or fully closed reports 0x3061.
// - A second correction latch before positioning completes reports 0x3070.
module afc_top #(
    parameter int AXES = afc_pkg::NUM_AXES
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [AXES-1:0] GRP_CHG,
    input wire logic [AXES-1:0] GRP_BAD,
    input wire logic [AXES-1:0] BUSY,
    input wire logic [AXES-1:0] STOP_REQ,
    input wire logic [AXES-1:0] PULSER_EN,
    input wire logic [AXES-1:0] MOVE_REQ,
    input wire logic [AXES*32-1:0] MOVE_AMT,
    input wire logic [AXES-1:0] INTERP_MEMBER,
    input wire logic [AXES-1:0] SYNC_MEMBER,
    input wire logic [AXES-1:0] SYNC_SET_REQ,
    input wire logic [AXES-1:0] TRQ_OVER,
    input wire logic [AXES-1:0] SPD_OVER,
    input wire logic [AXES-1:0] HOME_REQ,
    input wire logic [AXES-1:0] HOME_BAD,
    input wire logic [AXES-1:0] MTCLR_REQ,
    input wire logic [AXES-1:0] SERVO_ON,
    input wire logic [AXES-1:0] INCR_MODE,
    input wire logic [AXES-1:0] ABS_SINGLE,
    input wire logic [AXES-1:0] FULL_CLOSED,
    input wire logic [AXES-1:0] LATCH_TRIG,
    input wire logic [AXES-1:0] POS_DONE,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [AXES-1:0] AXIS_ERR,
    output logic [AXES-1:0] AXIS_STOP,
    output logic IRQ
);
    if (AXES < 2 || AXES > 8) begin : g_bad_axes
        $error("AXES must be 2 to 8");
    end

    localparam int NIN = 21;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [NIN*AXES-1:0] raw_in;
    logic [NIN*AXES-1:0] syn_in;
    logic [AXES*32-1:0] move_amt_s;
    assign raw_in = {GRP_CHG, GRP_BAD, BUSY, STOP_REQ, PULSER_EN, MOVE_REQ, INTERP_MEMBER, SYNC_MEMBER,
                     SYNC_SET_REQ, TRQ_OVER, SPD_OVER, HOME_REQ, HOME_BAD, MTCLR_REQ, SERVO_ON, INCR_MODE,
                     ABS_SINGLE, FULL_CLOSED, LATCH_TRIG, POS_DONE, {AXES{1'b0}}};
    afc_sync2 #(.W(NIN*AXES)) u_sync_bits (
        .clk(SYS_CLK),
        .rst(RST),
        .d(raw_in),
        .q(syn_in)
    );
    afc_sync2 #(.W(AXES*32)) u_sync_amt (
        .clk(SYS_CLK),
        .rst(RST),
        .d(MOVE_AMT),
        .q(move_amt_s)
    );
    wire logic [AXES-1:0] s_grp_chg = syn_in[20*AXES +: AXES];
    wire logic [AXES-1:0] s_grp_bad = syn_in[19*AXES +: AXES];
    wire logic [AXES-1:0] s_busy = syn_in[18*AXES +: AXES];
    wire logic [AXES-1:0] s_stop_req = syn_in[17*AXES +: AXES];
    wire logic [AXES-1:0] s_pulser = syn_in[16*AXES +: AXES];
    wire logic [AXES-1:0] s_move_req = syn_in[15*AXES +: AXES];
    wire logic [AXES-1:0] s_interp = syn_in[14*AXES +: AXES];
    wire logic [AXES-1:0] s_sync = syn_in[13*AXES +: AXES];
    wire logic [AXES-1:0] s_sync_set = syn_in[12*AXES +: AXES];
    wire logic [AXES-1:0] s_trq = syn_in[11*AXES +: AXES];
    wire logic [AXES-1:0] s_spd = syn_in[10*AXES +: AXES];
    wire logic [AXES-1:0] s_home_req = syn_in[9*AXES +: AXES];
    wire logic [AXES-1:0] s_home_bad = syn_in[8*AXES +: AXES];
    wire logic [AXES-1:0] s_mtclr = syn_in[7*AXES +: AXES];
    wire logic [AXES-1:0] s_servo = syn_in[6*AXES +: AXES];
    wire logic [AXES-1:0] s_incr = syn_in[5*AXES +: AXES];
    wire logic [AXES-1:0] s_abs1 = syn_in[4*AXES +: AXES];
    wire logic [AXES-1:0] s_fclo = syn_in[3*AXES +: AXES];
    wire logic [AXES-1:0] s_latch = syn_in[2*AXES +: AXES];
    wire logic [AXES-1:0] s_done = syn_in[1*AXES +: AXES];

    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [AXES-1:0] status_r;
    logic [AXES-1:0] mask_r;
    logic [3:0] mon_r;
    logic [31:0] move_hi_r;
    logic [31:0] move_lo_r;
    logic [AXES-1:0] err_vec;
    logic [AXES-1:0] stop_vec;
    logic [AXES-1:0] evt_vec;
    logic [AXES*32-1:0] code_vec;
    logic [AXES-1:0] clr_vec;

    // error on an axis, seen from its peers in the same group
    logic [AXES-1:0] own_err_r;
    wire logic interp_any = |(own_err_r & s_interp);
    wire logic sync_any = |(own_err_r & s_sync);
    wire logic sync_slave_off = |(s_sync & ~s_servo);

    genvar g;
    generate
        for (g = 0; g < AXES; g++) begin : g_axis
            afc_axis u_axis (
                .clk(SYS_CLK),
                .rst(RST),
                .grp_chg(s_grp_chg[g]),
                .grp_bad(s_grp_bad[g]),
                .busy(s_busy[g]),
                .stop_req(s_stop_req[g]),
                .pulser_en(s_pulser[g]),
                .move_req(s_move_req[g]),
                .move_amt(move_amt_s[g*32 +: 32]),
                .move_hi(move_hi_r),
                .move_lo(move_lo_r),
                .interp_peer_err(s_interp[g] && !own_err_r[g] && interp_any),
                .sync_peer_err(s_sync[g] && !own_err_r[g] && sync_any),
                .sync_set_req(s_sync_set[g]),
                .sync_slave_off(sync_slave_off),
                .mon_set(mon_r),
                .trq_over(s_trq[g]),
                .spd_over(s_spd[g]),
                .home_req(s_home_req[g]),
                .home_bad(s_home_bad[g]),
                .mtclr_req(s_mtclr[g]),
                .servo_on(s_servo[g]),
                .incr_mode(s_incr[g]),
                .abs_single(s_abs1[g]),
                .full_closed(s_fclo[g]),
                .latch_trig(s_latch[g]),
                .pos_done(s_done[g]),
                .clr(clr_vec[g]),
                .err_r(err_vec[g]),
                .code_r(code_vec[g*32 +: 32]),
                .stop_r(stop_vec[g]),
                .event_r(evt_vec[g])
            );
        end
    endgenerate

    // own_err marks an axis whose error came from itself, not a peer
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            own_err_r <= '0;
        end else begin
            own_err_r <= evt_vec & ~stop_vec;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel
    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    wire logic aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
    wire logic w_take = S_AXI_WVALID && S_AXI_WREADY;
    wire logic have_aw = aw_hold_r || aw_take;
    wire logic have_w = w_hold_r || w_take;
    wire logic do_wr = have_aw && have_w && !S_AXI_BVALID;
    wire logic [7:0] wa = aw_hold_r ? aw_addr_r : S_AXI_AWADDR;
    wire logic [31:0] wd = w_hold_r ? w_data_r : S_AXI_WDATA;
    wire logic [3:0] ws = w_hold_r ? w_strb_r : S_AXI_WSTRB;
    wire logic [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
    wire logic wr_status = do_wr && wa == afc_pkg::REG_STATUS;
    wire logic wr_mask = do_wr && wa == afc_pkg::REG_MASK;
    wire logic wr_mon = do_wr && wa == afc_pkg::REG_MONSET;
    wire logic wr_hi = do_wr && wa == afc_pkg::REG_MOVE_HI;
    wire logic wr_lo = do_wr && wa == afc_pkg::REG_MOVE_LO;
    wire logic wr_ok = wr_status || wr_mask || wr_mon || wr_hi || wr_lo;
    wire logic [31:0] wd_m = wd & wmask;
    assign clr_vec = wr_status ? wd_m[AXES-1:0] : '0;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= afc_pkg::RESP_OKAY;
        end else begin
            S_AXI_AWREADY <= !have_aw && !S_AXI_BVALID;
            S_AXI_WREADY <= !have_w && !S_AXI_BVALID;
            if (aw_take && !do_wr) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR;
            end else if (do_wr) begin
                aw_hold_r <= 1'b0;
            end
            if (w_take && !do_wr) begin
                w_hold_r <= 1'b1;
                w_data_r <= S_AXI_WDATA;
                w_strb_r <= S_AXI_WSTRB;
            end else if (do_wr) begin
                w_hold_r <= 1'b0;
            end
            if (do_wr) begin
                S_AXI_AWREADY <= 1'b0;
                S_AXI_WREADY <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_ok ? afc_pkg::RESP_OKAY : afc_pkg::RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY <= 1'b1;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            mask_r <= '0;
            mon_r <= afc_pkg::MON_RST;
            move_hi_r <= afc_pkg::MOVE_HI_RST;
            move_lo_r <= afc_pkg::MOVE_LO_RST;
        end else begin
            if (wr_mask) mask_r <= (mask_r & ~wmask[AXES-1:0]) | wd_m[AXES-1:0];
            if (wr_mon) mon_r <= (mon_r & ~wmask[3:0]) | wd_m[3:0];
            if (wr_hi) move_hi_r <= (move_hi_r & ~wmask) | wd_m;
            if (wr_lo) move_lo_r <= (move_lo_r & ~wmask) | wd_m;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status: set wins over write-one-to-clear
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            status_r <= '0;
            IRQ <= 1'b0;
            AXIS_ERR <= '0;
            AXIS_STOP <= '0;
        end else begin
            status_r <= (status_r & ~clr_vec) | evt_vec;
            IRQ <= |(status_r & mask_r);
            AXIS_ERR <= err_vec;
            AXIS_STOP <= stop_vec;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    wire logic [7:0] ra = S_AXI_ARADDR;
    wire logic [7:0] code_off = ra - afc_pkg::REG_CODE0;
    wire logic in_code = ra >= afc_pkg::REG_CODE0 && code_off[7:2] < 6'(AXES) && ra[1:0] == 2'h0;
    logic [31:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_val = '0;
        rd_ok = 1'b1;
        if (in_code) begin
            rd_val = code_vec[code_off[4:2]*32 +: 32];
        end else begin
            case (ra)
                afc_pkg::REG_STATUS: rd_val[AXES-1:0] = status_r;
                afc_pkg::REG_MASK: rd_val[AXES-1:0] = mask_r;
                afc_pkg::REG_MONSET: rd_val[3:0] = mon_r;
                afc_pkg::REG_MOVE_HI: rd_val = move_hi_r;
                afc_pkg::REG_MOVE_LO: rd_val = move_lo_r;
                default: rd_ok = 1'b0;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= afc_pkg::RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_val;
            S_AXI_RRESP <= rd_ok ? afc_pkg::RESP_OKAY : afc_pkg::RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end else if (!S_AXI_RVALID) begin
            S_AXI_ARREADY <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** tb/afc_asserts.sv ***
// concurrent checks on the fault detector top ports
`timescale 1ns/1ps
`default_nettype none
module afc_asserts #(
    parameter int AXES = 4
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [AXES-1:0] GRP_CHG,
    input wire logic [AXES-1:0] PULSER_EN,
    input wire logic [AXES-1:0] HOME_REQ,
    input wire logic [AXES-1:0] HOME_BAD,
    input wire logic [AXES-1:0] MTCLR_REQ,
    input wire logic [AXES-1:0] SERVO_ON,
    input wire logic [AXES-1:0] INCR_MODE,
    input wire logic [AXES-1:0] ABS_SINGLE,
    input wire logic [AXES-1:0] FULL_CLOSED,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [AXES-1:0] AXIS_ERR,
    input wire logic [AXES-1:0] AXIS_STOP
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////
    sequence pulser_chg_s;
        (GRP_CHG[0] && PULSER_EN[0]) [*3];
    endsequence
    sequence home_bad_s;
        (HOME_REQ[0] && HOME_BAD[0]) [*3];
    endsequence
    sequence mtclr_bad_s;
        (MTCLR_REQ[0] && (SERVO_ON[0] || INCR_MODE[0] || ABS_SINGLE[0] || FULL_CLOSED[0])) [*3];
    endsequence
    sequence both_taken_s;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    pulser_flag_a: assert property (pulser_chg_s |-> ##[1:3] AXIS_ERR[0])
        else $error("group change in pulser mode not flagged");
    home_flag_a: assert property (home_bad_s |-> ##[1:3] AXIS_ERR[0])
        else $error("impossible home return not flagged");
    mtclr_flag_a: assert property (mtclr_bad_s |-> ##[1:3] AXIS_ERR[0])
        else $error("refused multi-turn clear not flagged");
    peer_stop_a: assert property ($rose(AXIS_STOP[1]) |-> ##[0:2] AXIS_ERR[1])
        else $error("peer stop without error flag");
    aw_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write accepted while response pending");
    ar_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read accepted while data pending");
    rvalid_lat_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
    bvalid_lat_a: assert property (both_taken_s |=> S_AXI_BVALID)
        else $error("write answer late");
    b_done_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY)
        else $error("write channel not reopened");
endmodule
`default_nettype wire

// *** tb/afc_amp_model.sv ***
// servo amplifier status model answering one cycle after the command, or two cycles when slow
`timescale 1ns/1ps
`default_nettype none
module afc_amp_model #(
    parameter int N = 4
) (
    input wire logic clk,
    input wire logic slow,
    input wire logic [N-1:0] srv_cmd,
    input wire logic [N-1:0] trq_cmd,
    input wire logic [N-1:0] spd_cmd,
    output logic [N-1:0] servo_on,
    output logic [N-1:0] trq_over,
    output logic [N-1:0] spd_over
);
    logic [3*N-1:0] stage1_r;
    logic [3*N-1:0] stage2_r;
    always_ff @(posedge clk) begin
        stage1_r <= {srv_cmd, trq_cmd, spd_cmd};
        stage2_r <= stage1_r;
    end
    assign {servo_on, trq_over, spd_over} = slow ? stage2_r : stage1_r;
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the axis fault code detector
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic SYS_CLK, RST, slow, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
    logic [3:0] GRP_CHG, GRP_BAD, BUSY, STOP_REQ, PULSER_EN, MOVE_REQ, INTERP_MEMBER, SYNC_MEMBER, SYNC_SET_REQ;
    logic [3:0] HOME_REQ, HOME_BAD, MTCLR_REQ, INCR_MODE, ABS_SINGLE, FULL_CLOSED, LATCH_TRIG, POS_DONE;
    logic [3:0] srv_cmd, trq_cmd, spd_cmd, S_AXI_WSTRB;
    logic [127:0] MOVE_AMT;
    logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR, a;
    logic [31:0] S_AXI_WDATA, c;
    wire logic [3:0] SERVO_ON, TRQ_OVER, SPD_OVER, AXIS_ERR, AXIS_STOP;
    wire logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, IRQ;
    wire logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    wire logic [31:0] S_AXI_RDATA;
    logic [1:0] wq[$];
    logic [33:0] rq[$];
    int n_fail = 0;
    int tests_run = 0;
    afc_top afc_top_inst (.*);
    afc_amp_model #(.N(4)) afc_amp_model_inst (.clk(SYS_CLK), .slow(slow), .srv_cmd(srv_cmd), .trq_cmd(trq_cmd),
        .spd_cmd(spd_cmd), .servo_on(SERVO_ON), .trq_over(TRQ_OVER), .spd_over(SPD_OVER));
    initial begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
        wq.push_back(r);
        S_AXI_AWADDR <= ad;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        do begin
            @(posedge SYS_CLK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end while (!S_AXI_BVALID);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
        rq.push_back({r, d});
        S_AXI_ARADDR <= ad;
        S_AXI_ARVALID <= 1'b1;
        do begin
            @(posedge SYS_CLK);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while (!S_AXI_RVALID);
    endtask
    // watches the response channels and matches the oldest note
    always @(posedge SYS_CLK) begin
        if (S_AXI_BVALID && S_AXI_BREADY) chk({32'h0, S_AXI_BRESP}, {32'h0, wq.pop_front()});
        if (S_AXI_RVALID && S_AXI_RREADY) chk({S_AXI_RRESP, S_AXI_RDATA}, rq.pop_front());
    end
    task automatic idle();
        {GRP_CHG, GRP_BAD, BUSY, STOP_REQ, PULSER_EN, MOVE_REQ, INTERP_MEMBER, SYNC_MEMBER, SYNC_SET_REQ} <= '0;
        {HOME_REQ, HOME_BAD, MTCLR_REQ, INCR_MODE, ABS_SINGLE, FULL_CLOSED, LATCH_TRIG, trq_cmd, spd_cmd} <= '0;
        srv_cmd <= 4'hF;
        POS_DONE <= 4'hF;
    endtask
    // drives one fault case on axis 0, notes the code and the register to read
    task automatic stim(input int k);
        int r3;
        int r4;
        logic [31:0] hi;
        r3 = $urandom % 3;
        r4 = $urandom % 4;
        hi = $urandom & 32'h0FFF_FFFF;
        a = afc_pkg::REG_CODE0;
        POS_DONE <= 4'h0;
        case (k)
            0: begin c = afc_pkg::CODE_PULSER; GRP_CHG[0] <= 1'b1; PULSER_EN[0] <= 1'b1; end
            1: begin c = afc_pkg::CODE_GROUP_OP; GRP_CHG[0] <= (r3 != 0); GRP_BAD[0] <= (r3 == 0);
                BUSY[0] <= (r3 == 1); STOP_REQ[0] <= (r3 == 2); end
            2: begin c = afc_pkg::CODE_INTERP; a = 8'h24; INTERP_MEMBER <= 4'h3; HOME_REQ[0] <= 1'b1; end
            3: begin c = afc_pkg::CODE_MOVE_AMT; wr(afc_pkg::REG_MOVE_HI, hi, afc_pkg::RESP_OKAY);
                MOVE_AMT[31:0] <= hi + 32'h0000_0001; MOVE_REQ[0] <= 1'b1; end
            4: begin c = afc_pkg::CODE_SYNC; a = 8'h24; SYNC_MEMBER <= 4'h3; HOME_REQ[0] <= 1'b1; end
            5: begin c = afc_pkg::CODE_SYNC_SET; SYNC_MEMBER <= 4'h2; srv_cmd <= 4'hD; SYNC_SET_REQ[0] <= 1'b1; end
            6: begin c = afc_pkg::CODE_TORQUE; wr(afc_pkg::REG_MONSET, 32'h1, 2'h0); trq_cmd[0] <= 1'b1; end
            7: begin c = afc_pkg::CODE_SPEED; wr(afc_pkg::REG_MONSET, 32'h4, 2'h0); spd_cmd[0] <= 1'b1; end
            8: begin c = afc_pkg::CODE_HOME; HOME_REQ[0] <= 1'b1; end
            9: begin c = afc_pkg::CODE_MTCLR; MTCLR_REQ[0] <= 1'b1; srv_cmd <= {3'h7, r4 == 0};
                INCR_MODE[0] <= (r4 == 1); ABS_SINGLE[0] <= (r4 == 2); FULL_CLOSED[0] <= (r4 == 3); end
            default: begin c = afc_pkg::CODE_LATCH; LATCH_TRIG[0] <= 1'b1; end
        endcase
        if (k == 2 || k == 4 || k == 8) HOME_BAD[0] <= 1'b1;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #300000;
        n_fail++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(94870));
        RST <= 1'b1;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID, slow} <= '0;
        {S_AXI_BREADY, S_AXI_RREADY} <= 2'b11;
        S_AXI_WSTRB <= 4'hF;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, MOVE_AMT} <= '0;
        idle();
        repeat (4) @(posedge SYS_CLK);
        RST <= 1'b0;
        rd(afc_pkg::REG_MOVE_HI, afc_pkg::MOVE_HI_RST, afc_pkg::RESP_OKAY);
        rd(afc_pkg::REG_MOVE_LO, afc_pkg::MOVE_LO_RST, afc_pkg::RESP_OKAY);
        rd(afc_pkg::REG_MONSET, 32'h0, afc_pkg::RESP_OKAY);
        rd(afc_pkg::REG_STATUS, 32'h0, afc_pkg::RESP_OKAY);
        wr(8'h40, 32'hFFFF_FFFF, afc_pkg::RESP_SLVERR);
        wr(afc_pkg::REG_CODE0, 32'h1, afc_pkg::RESP_SLVERR);
        for (int k = 0; k < 11; k++) begin
            slow <= k[0];
            wr(afc_pkg::REG_MASK, (k == 4) ? 32'h0 : 32'hF, afc_pkg::RESP_OKAY);
            stim(k);
            repeat (3) @(posedge SYS_CLK);
            idle();
            repeat (8) @(posedge SYS_CLK);
            chk({29'h0, AXIS_ERR, IRQ}, {31'h0, k == 2 || k == 4, 1'b1, k != 4});
            rd(a, c, afc_pkg::RESP_OKAY);
            wr(afc_pkg::REG_STATUS, 32'hF, afc_pkg::RESP_OKAY);
            rd(a, 32'h0, afc_pkg::RESP_OKAY);
            chk({29'h0, AXIS_ERR, IRQ}, 34'h0);
        end
        give_verdict();
    end
endmodule
bind afc_top afc_asserts #(.AXES(AXES)) afc_asserts_inst (.*);
`default_nettype wire
